// ### core/rgbm_cfg.svh
// Purpose: Offsets, field positions, reset values and widths of the RGB input mux.
// Assumes: Registers sit at byte addresses on an 8-bit address of the plain port.
// Notes:   Definitions only; included by its bare name.
`ifndef RGBM_CFG_SVH
`define RGBM_CFG_SVH

// Register byte addresses.
`define RGBM_ADDR_CTRL      8'h00
`define RGBM_ADDR_DIVN      8'h04
`define RGBM_ADDR_GPO       8'h08
`define RGBM_ADDR_STATUS    8'h0c

// Control register field positions.
`define RGBM_CTRL_DIV_POL   0
`define RGBM_CTRL_CLAMP_POL 1
`define RGBM_CTRL_CLAMP_EN  2
`define RGBM_CTRL_HS_LEVEL  3

// Reset values.
`define RGBM_CTRL_RST       4'h4
`define RGBM_DIVN_RST       8'h02
`define RGBM_GPO_RST        8'h00

// Widths.
`define RGBM_ADDR_W         8
`define RGBM_DATA_W         32
`define RGBM_SYNC_W         29

`endif

// ### core/rgbm_pkg.sv
// Purpose: Shared types of the RGB input mux.
// Assumes: Constants live in rgbm_cfg.svh.
// Notes:   Nothing here is imported; users write rgbm_pkg::name.
package rgbm_pkg;

    typedef logic [7:0] rgbm_byte_t;

    // Source of the pixel words, one-hot.
    typedef enum logic [1:0] {
        RGBM_SRC_ADC = 2'b01,
        RGBM_SRC_EXT = 2'b10
    } rgbm_src_t;

    typedef struct packed {
        rgbm_byte_t red;
        rgbm_byte_t green;
        rgbm_byte_t blue;
    } rgbm_pix_t;

endpackage : rgbm_pkg

// ### core/rgbm_clk_if.sv
// Purpose: Carrier between the pin mux core and its clock unit.
// Assumes: Both ends run on the same clock.
// Notes:   No clocking block.
`timescale 1ns/1ps
`default_nettype none
interface rgbm_clk_if;
    logic                ext_clk_lvl;
    logic                pll_tick;
    logic                src_pll;
    rgbm_pkg::rgbm_byte_t divn;
    logic                div_pol;
    logic                clamp_pol;
    logic                clamp_en;
    logic                hs_active;
    logic                sample_tick;
    logic                div_out;
    logic                clamp_out;

    modport unit (
        input  ext_clk_lvl, pll_tick, src_pll, divn, div_pol,
        input  clamp_pol, clamp_en, hs_active,
        output sample_tick, div_out, clamp_out
    );
    modport core (
        output ext_clk_lvl, pll_tick, src_pll, divn, div_pol,
        output clamp_pol, clamp_en, hs_active,
        input  sample_tick, div_out, clamp_out
    );
endinterface : rgbm_clk_if
`default_nettype wire

// ### core/rgbm_clk_unit.sv
// Purpose: Sample clock source choice, divided clock output and clamp indication.
// Assumes: The external sample clock level is already synchronised.
// Notes:   The external clock is seen as an edge strobe, so it must run below clk/2.
`timescale 1ns/1ps
`default_nettype none
`include "rgbm_cfg.svh"
module rgbm_clk_unit (
    input  wire logic clk,
    input  wire logic srst,
    rgbm_clk_if.unit  cif
);
    logic                 ext_prev_q;
    logic                 ext_edge;
    rgbm_pkg::rgbm_byte_t cnt_q;
    rgbm_pkg::rgbm_byte_t cnt_d;
    rgbm_pkg::rgbm_byte_t half;
    logic                 div_q;
    logic                 clamp_q;

    // Rising edge of the external clock, and the strobe of the chosen source.
    assign ext_edge        = cif.ext_clk_lvl & ~ext_prev_q;
    assign cif.sample_tick = cif.src_pll ? cif.pll_tick : ext_edge; // RL2

    // Edge counter wraps after N edges; the output is high for the first half.
    assign cnt_d = !ext_edge ? cnt_q :
                   (cnt_q + 8'h01 >= cif.divn) ? 8'h00 : cnt_q + 8'h01; // RL3
    assign half  = cif.divn >> 1;

    // Divider and clamp flops; div_out and clamp_out come from a register, sample_tick does not.
    always_ff @(posedge clk) begin
        if (srst) begin // RL1
            ext_prev_q <= 1'b0;
            cnt_q      <= 8'h00;
            div_q      <= 1'b0;
            clamp_q    <= 1'b0;
        end else begin
            ext_prev_q <= cif.ext_clk_lvl;
            cnt_q      <= cnt_d;
            div_q      <= (cnt_d < half) ^ cif.div_pol; // RL3
            clamp_q    <= (cif.clamp_en & cif.hs_active) ^ cif.clamp_pol; // RL4
        end
    end

    assign cif.div_out   = div_q;
    assign cif.clamp_out = clamp_q;
endmodule : rgbm_clk_unit
`default_nettype wire

// ### core/rgbm_pin_mux.sv
// Purpose: Input path selection and pin sharing of the digital RGB port.
// Assumes: One 100 MHz clock; pins and the sample clock pass two flops first.
// Notes:   The analog converter words and the encoder syncs come from same-clock logic.
// How it works
// RL1: Reset high returns every register and state to its default.
// RL2: Source select high clocks sampling from the PLL, low from the external clock.
// RL3: External sample clock divided by N is driven out with selectable polarity.
// RL4: Clamp indication is high while clamping during line sync; polarity selectable.
// RL5: Select low takes converter words, high takes the external 24-bit pins.
// RL6: Blue pins are data inputs when selected, otherwise general outputs.
// RL7: Red bit 2 is data when selected, otherwise the overlay enable input.
// RL8: Red bits 1 and 0 are data, otherwise the TV line and frame syncs.
// RL9: Green bits 7,4,5,6 are data, otherwise overlay half-tone, red, green, blue.
// RL10: Red joins five upper and three shared bits; green four own and four shared.
// RL11: Up to eight general outputs follow the general output register.
// RL12: With the CPU enabled, output bit 0 shows the line-rate high flag.
// RL13: The internal CPU runs only while its enable input is high.
// RL14: Pin direction of shared pins follows the synchronised select.
//
// The implementer's own choices: the register offsets and the address-and-strobe port.

`timescale 1ns/1ps
`default_nettype none
`include "rgbm_cfg.svh"
module rgbm_pin_mux (
    input  wire logic                    clk,
    input  wire logic                    srst,

    // Register port.
    input  wire logic [`RGBM_ADDR_W-1:0] reg_addr,
    input  wire logic [`RGBM_DATA_W-1:0] reg_wdata,
    input  wire logic                    reg_wr,
    input  wire logic                    reg_rd,
    output logic      [`RGBM_DATA_W-1:0] reg_rdata,

    // Control pins.
    input  wire logic                    sample_clock_source_select_n,
    input  wire logic                    external_sample_clock_in,
    input  wire logic                    incoming_line_sync,
    input  wire logic                    digital_rgb_select,
    input  wire logic                    internal_cpu_enable,
    output logic                         divided_sample_clock_out,
    output logic                         clamp_ref_out,

    // Pixel pins, dedicated and shared.
    input  wire logic [4:0]              red_hi_in,
    input  wire logic                    red2_in,
    input  wire logic [1:0]              red_lo_in,
    output logic      [1:0]              red_lo_out,
    output logic      [1:0]              red_lo_oe,
    input  wire logic [3:0]              green_hi_in,
    input  wire logic [3:0]              green_lo_in,
    input  wire logic [7:0]              blue_in,
    output logic      [7:0]              blue_out,
    output logic      [7:0]              blue_oe,

    // Internal side.
    input  wire logic                    pll_sample_tick,
    input  wire logic [7:0]              adc_red,
    input  wire logic [7:0]              adc_green,
    input  wire logic [7:0]              adc_blue,
    input  wire logic                    tv_line_sync_in,
    input  wire logic                    tv_frame_sync_in,
    input  wire logic                    line_rate_high,
    output logic                         sample_tick,
    output rgbm_pkg::rgbm_pix_t          pixel,
    output logic                         pixel_valid,
    output rgbm_pkg::rgbm_src_t          pixel_source,
    output logic                         internal_cpu_run,
    output logic                         overlay_enable,
    output logic                         overlay_halftone,
    output logic                         overlay_red,
    output logic                         overlay_green,
    output logic                         overlay_blue
);
    // Raw pin vector: every bit of it crosses in from outside the clock domain.
    logic [`RGBM_SYNC_W-1:0] raw;
    logic [`RGBM_SYNC_W-1:0] meta_q;
    logic [`RGBM_SYNC_W-1:0] sync_q;

    assign raw = {sample_clock_source_select_n,
                  external_sample_clock_in,
                  incoming_line_sync,
                  digital_rgb_select,
                  internal_cpu_enable,
                  red_hi_in,
                  red2_in,
                  red_lo_in,
                  green_hi_in,
                  green_lo_in,
                  blue_in};

    // Two-flop synchronisers, one per pin bit; only the second flop is read.
    // A pin high as reset ends looks like a fresh rise.
    genvar gi;
    generate
        for (gi = 0; gi < `RGBM_SYNC_W; gi++) begin : g_sync
            always_ff @(posedge clk) begin
                if (srst) begin // RL1
                    meta_q[gi] <= 1'b0;
                    sync_q[gi] <= 1'b0;
                end else begin
                    meta_q[gi] <= raw[gi];
                    sync_q[gi] <= meta_q[gi];
                end
            end
        end
    endgenerate

    // Named views of the synchronised pins.
    logic       src_pll_s;
    logic       ext_clk_s;
    logic       hs_s;
    logic       dig_sel_s;
    logic       cpu_en_s;

    logic [4:0] red_hi_s;
    logic       red2_s;
    logic [1:0] red_lo_s;
    logic [3:0] green_hi_s;
    logic [3:0] green_lo_s;
    logic [7:0] blue_s;

    assign src_pll_s  = sync_q[28];
    assign ext_clk_s  = sync_q[27];
    assign hs_s       = sync_q[26];
    assign dig_sel_s  = sync_q[25];
    assign cpu_en_s   = sync_q[24];

    assign red_hi_s   = sync_q[23:19];
    assign red2_s     = sync_q[18];
    assign red_lo_s   = sync_q[17:16];
    assign green_hi_s = sync_q[15:12];
    assign green_lo_s = sync_q[11:8];
    assign blue_s     = sync_q[7:0];

    // Software registers.
    logic [3:0]           ctrl_q;
    rgbm_pkg::rgbm_byte_t divn_q;
    rgbm_pkg::rgbm_byte_t gpo_q;

    logic [`RGBM_DATA_W-1:0] rdata_q;

    // Write decode.
    logic wr_ctrl;
    logic wr_divn;
    logic wr_gpo;

    // Status and unmapped writes are dropped.
    assign wr_ctrl = reg_wr && (reg_addr == `RGBM_ADDR_CTRL);
    assign wr_divn = reg_wr && (reg_addr == `RGBM_ADDR_DIVN);
    assign wr_gpo  = reg_wr && (reg_addr == `RGBM_ADDR_GPO);

    // Register writes; the general output register is loaded only by software.
    always_ff @(posedge clk) begin
        if (srst) begin // RL1
            ctrl_q <= `RGBM_CTRL_RST;
            divn_q <= `RGBM_DIVN_RST;
            gpo_q  <= `RGBM_GPO_RST;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[3:0];
            if (wr_divn) divn_q <= reg_wdata[7:0];
            if (wr_gpo)  gpo_q  <= reg_wdata[7:0]; // RL11
        end
    end

    // Status word: live state of the selects, the CPU gate and line sync.
    logic [`RGBM_DATA_W-1:0] status_w;
    logic [`RGBM_DATA_W-1:0] rd_mux;

    assign status_w = {27'h0000000,
                       hs_s,
                       line_rate_high,
                       cpu_en_s,
                       src_pll_s,
                       dig_sel_s};

    // Read selection; unmapped addresses read as zero.
    assign rd_mux = (reg_addr == `RGBM_ADDR_CTRL)   ? {28'h0000000, ctrl_q} :
                    (reg_addr == `RGBM_ADDR_DIVN)   ? {24'h000000, divn_q}  :
                    (reg_addr == `RGBM_ADDR_GPO)    ? {24'h000000, gpo_q}   :
                    (reg_addr == `RGBM_ADDR_STATUS) ? status_w              :
                    32'h00000000;

    // Read data stand for exactly the cycle after the strobe, zero otherwise.
    always_ff @(posedge clk) begin
        if (srst) begin // RL1
            rdata_q <= 32'h00000000;
        end else begin
            rdata_q <= reg_rd ? rd_mux : 32'h00000000;
        end
    end

    assign reg_rdata = rdata_q;

    // Clock unit: source choice, divider and clamp indication.
    rgbm_clk_if cif ();

    assign cif.ext_clk_lvl = ext_clk_s;
    assign cif.pll_tick    = pll_sample_tick;
    assign cif.src_pll     = src_pll_s; // RL2
    assign cif.divn        = divn_q;

    assign cif.div_pol     = ctrl_q[`RGBM_CTRL_DIV_POL];
    assign cif.clamp_pol   = ctrl_q[`RGBM_CTRL_CLAMP_POL];
    assign cif.clamp_en    = ctrl_q[`RGBM_CTRL_CLAMP_EN];
    // Line sync counts as active at the level software names, either polarity.
    assign cif.hs_active   = ~(hs_s ^ ctrl_q[`RGBM_CTRL_HS_LEVEL]); // RL4

    rgbm_clk_unit u_clk (
        .clk  (clk),
        .srst (srst),
        .cif  (cif)
    );

    assign divided_sample_clock_out = cif.div_out; // RL3
    assign clamp_ref_out            = cif.clamp_out; // RL4
    assign sample_tick              = cif.sample_tick;

    // External words: shared pins fill red bits 2..0 and green bits 7..4.
    rgbm_pkg::rgbm_pix_t ext_pix;
    rgbm_pkg::rgbm_pix_t adc_pix;
    rgbm_pkg::rgbm_pix_t sel_pix;

    assign ext_pix.red   = {red_hi_s, red2_s, red_lo_s}; // RL10
    assign ext_pix.green = {green_hi_s, green_lo_s}; // RL10
    assign ext_pix.blue  = blue_s; // RL6

    assign adc_pix.red   = adc_red;
    assign adc_pix.green = adc_green;
    assign adc_pix.blue  = adc_blue;

    assign sel_pix       = dig_sel_s ? ext_pix : adc_pix; // RL5

    // Pixel register, loaded on each sample strobe of the chosen clock source.
    // Tag and word are taken together.
    rgbm_pkg::rgbm_pix_t pix_q;
    logic                pix_valid_q;
    rgbm_pkg::rgbm_src_t src_q;

    always_ff @(posedge clk) begin
        if (srst) begin // RL1
            pix_q       <= '0;
            pix_valid_q <= 1'b0;
            src_q       <= rgbm_pkg::RGBM_SRC_ADC;
        end else begin
            pix_valid_q <= cif.sample_tick; // RL2
            if (cif.sample_tick) begin
                pix_q <= sel_pix; // RL5
                src_q <= dig_sel_s ? rgbm_pkg::RGBM_SRC_EXT : rgbm_pkg::RGBM_SRC_ADC;
            end
        end
    end

    assign pixel        = pix_q;
    assign pixel_valid  = pix_valid_q;
    assign pixel_source = src_q;

    // Pin roles. Enables drop on the edge the data switch and return one cycle later, from the same
    // synchronised select, so a pin is never driven while read as data.
    logic [7:0] gpo_pin_q;
    logic [1:0] tv_sync_q;
    logic       drive_q;
    logic       cpu_run_q;
    logic [4:0] ovl_q;

    always_ff @(posedge clk) begin
        if (srst) begin // RL1
            gpo_pin_q <= `RGBM_GPO_RST;
            tv_sync_q <= 2'b00;
            drive_q   <= 1'b0;
            cpu_run_q <= 1'b0;
            ovl_q     <= 5'h00;
        end else begin
            cpu_run_q <= cpu_en_s; // RL13
            // Bit 0 reports the line rate only while the CPU runs.
            gpo_pin_q <= {gpo_q[7:1], cpu_en_s ? line_rate_high : gpo_q[0]}; // RL12
            tv_sync_q <= {tv_line_sync_in, tv_frame_sync_in}; // RL8
            // Drive returns one cycle after the select is seen low.
            drive_q   <= ~dig_sel_s; // RL14
            // Overlay inputs read as zero while the pins carry pixel data.
            ovl_q     <= dig_sel_s ? 5'h00 :
                         {red2_s, green_hi_s[3], green_hi_s[0],
                          green_hi_s[1], green_hi_s[2]}; // RL7 RL9
        end
    end

    // Shared outputs; the enables drop in the same cycle the select rises.
    assign blue_out   = gpo_pin_q; // RL6 RL11
    assign blue_oe    = {8{drive_q & ~dig_sel_s}}; // RL6 RL14
    assign red_lo_out = tv_sync_q; // RL8
    assign red_lo_oe  = {2{drive_q & ~dig_sel_s}}; // RL8 RL14

    // Role outputs come straight from flops.
    assign internal_cpu_run = cpu_run_q;

    assign overlay_enable   = ovl_q[4]; // RL7
    assign overlay_halftone = ovl_q[3]; // RL9
    assign overlay_red      = ovl_q[2]; // RL9
    assign overlay_green    = ovl_q[1]; // RL9
    assign overlay_blue     = ovl_q[0]; // RL9
endmodule : rgbm_pin_mux
`default_nettype wire

// ### verification/rgbm_partner.sv
// Purpose: Model of the digital RGB source and overlay controller at the pins.
// Assumes: The source drives data pins only while digital mode is selected.
// Notes:   Released lines show a pattern that flips every cycle.
`timescale 1ns/1ps
`default_nettype none
module rgbm_partner (
    input  wire logic        clk,
    input  wire logic        sel,
    input  wire logic [23:0] word,
    input  wire logic [4:0]  ovl,
    input  wire logic [1:0]  r_lo_out,
    input  wire logic [1:0]  r_lo_oe,
    input  wire logic [7:0]  b_out,
    input  wire logic [7:0]  b_oe,
    output logic      [4:0]  r_hi,
    output logic             r2,
    output logic      [1:0]  r_lo,
    output logic      [3:0]  g_hi,
    output logic      [3:0]  g_lo,
    output logic      [7:0]  b_in
);
    logic flip_q = 1'b0;
    // A toggling level keeps an undriven line from looking like stale data.
    always @(posedge clk) begin
        flip_q <= ~flip_q;
    end
    // Dedicated and shared pins carry the word only in digital mode.
    assign r_hi = sel ? word[23:19] : {5{flip_q}};
    assign g_lo = sel ? word[11:8] : {4{flip_q}};
    assign r2   = sel ? word[18] : ovl[0];
    assign g_hi = sel ? word[15:12] : {ovl[1], ovl[4], ovl[3], ovl[2]};
    // Wire level of the two-way pins; the device wins wherever it drives.
    assign r_lo = (r_lo_oe & r_lo_out) | (~r_lo_oe & (sel ? word[17:16] : {2{flip_q}}));
    assign b_in = (b_oe & b_out) | (~b_oe & (sel ? word[7:0] : {8{flip_q}}));
endmodule : rgbm_partner
`default_nettype wire

// ### verification/rgbm_pin_mux_checker.sv
// Purpose: Concurrent checks on the ports of the RGB input pin mux.
// Assumes: Pins pass two synchroniser flops before any use.
// Notes:   Antecedents on pin inputs wait out the synchroniser so reset tails never fire.
`timescale 1ns/1ps
`default_nettype none
module rgbm_pin_mux_checker (
    input wire logic                clk,
    input wire logic                srst,
    input wire logic                sample_clock_source_select_n,
    input wire logic                digital_rgb_select,
    input wire logic                internal_cpu_enable,
    input wire logic                red2_in,
    input wire logic [3:0]          green_hi_in,
    input wire logic [1:0]          red_lo_oe,
    input wire logic [7:0]          blue_out,
    input wire logic [7:0]          blue_oe,
    input wire logic                pll_sample_tick,
    input wire logic [7:0]          adc_red,
    input wire logic [7:0]          adc_green,
    input wire logic [7:0]          adc_blue,
    input wire logic                line_rate_high,
    input wire logic                sample_tick,
    input wire rgbm_pkg::rgbm_pix_t pixel,
    input wire logic                pixel_valid,
    input wire rgbm_pkg::rgbm_src_t pixel_source,
    input wire logic                internal_cpu_run,
    input wire logic                overlay_enable,
    input wire logic                overlay_halftone,
    input wire logic                overlay_red,
    input wire logic                overlay_green,
    input wire logic                overlay_blue
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    // Direction and overlay checks, each after the select has settled.
    oe_off_a: assert property (
        (digital_rgb_select && !srst) [*3] |-> blue_oe == 8'h00 && red_lo_oe == 2'b00)
        else $error("Shared pins driven in digital mode.");
    ovl_zero_a: assert property (
        (digital_rgb_select && !srst) [*4] |-> {overlay_enable, overlay_halftone,
        overlay_red, overlay_green, overlay_blue} == 5'h00)
        else $error("Overlay input seen in digital mode.");
    ovl_en_a: assert property (
        (!srst && !digital_rgb_select && $stable(red2_in)) [*4] |-> overlay_enable == red2_in)
        else $error("Overlay enable does not follow its pin.");
    ovl_tone_a: assert property (
        (!srst && !digital_rgb_select && $stable(green_hi_in)) [*4] |->
        {overlay_halftone, overlay_blue, overlay_green, overlay_red} == green_hi_in)
        else $error("Overlay colour inputs mapped wrongly.");
    // Sampling path checks.
    tick_src_a: assert property (
        (!srst && sample_clock_source_select_n) [*3] |-> sample_tick == pll_sample_tick)
        else $error("Sample strobe not taken from the loop.");
    pix_valid_a: assert property (sample_tick |=> pixel_valid)
        else $error("Pixel not valid after a sample strobe.");
    pix_adc_a: assert property (
        (!srst && !digital_rgb_select) [*4] ##0 sample_tick |=> pixel_source ==
        rgbm_pkg::RGBM_SRC_ADC && pixel == $past({adc_red, adc_green, adc_blue}))
        else $error("Converter word not passed to the pixel.");
    // Processor enable and the frequency flag on general output zero.
    cpu_run_a: assert property (
        (!srst && $stable(internal_cpu_enable)) [*4] |-> internal_cpu_run == internal_cpu_enable)
        else $error("Processor run differs from its enable.");
    gpo_flag_a: assert property (
        (!srst && internal_cpu_enable && !digital_rgb_select) [*4] |=>
        blue_out[0] == $past(line_rate_high))
        else $error("Output zero does not show the rate flag.");
endmodule : rgbm_pin_mux_checker
bind rgbm_pin_mux rgbm_pin_mux_checker rgbm_pin_mux_checker_inst (.*);
`default_nettype wire

// ### verification/testbench.sv
// Purpose: Self-checking bench of the RGB input pin mux.
// Assumes: One 100 MHz clock; reset held for 20 cycles at the start.
// Notes:   Drivers queue expected pixels and read data; a monitor compares them.
`timescale 1ns/1ps
`default_nettype none
`include "rgbm_cfg.svh"
module testbench;
    logic        clk = 0, srst = 1, reg_wr = 0, reg_rd = 0, rd_d = 0, watch = 1, dp;
    logic        src_n = 1, ext_ck = 0, hs = 0, sel = 0, cpu_en = 0, pll_tk = 0;
    logic        tv_l = 0, tv_f = 0, lrh = 0, div_o, clamp_o, tick, p_valid, cpu_run, r2;
    logic [7:0]  addr = 0, adc_r = 0, adc_g = 0, adc_b = 0, b_out, b_oe, b_in;
    logic [31:0] wdata = 0, rdata, g, st = 32'hd0639a1a;
    logic [23:0] word = 0;
    logic [4:0]  ovl = 0, r_hi, o;
    logic [3:0]  g_hi, g_lo;
    logic [1:0]  r_lo, r_lo_out, r_lo_oe;
    logic [25:0] pix_q[$];
    logic [31:0] rd_q[$];
    int          miscompares = 0, tests_run = 0, n_tk, n_div;
    rgbm_pkg::rgbm_pix_t pix;
    rgbm_pkg::rgbm_src_t src;
    rgbm_pin_mux rgbm_pin_mux_inst (.clk(clk), .srst(srst), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(rdata),
        .sample_clock_source_select_n(src_n), .external_sample_clock_in(ext_ck),
        .incoming_line_sync(hs), .digital_rgb_select(sel), .internal_cpu_enable(cpu_en),
        .divided_sample_clock_out(div_o), .clamp_ref_out(clamp_o), .red_hi_in(r_hi),
        .red2_in(r2), .red_lo_in(r_lo), .red_lo_out(r_lo_out), .red_lo_oe(r_lo_oe),
        .green_hi_in(g_hi), .green_lo_in(g_lo), .blue_in(b_in), .blue_out(b_out),
        .blue_oe(b_oe), .pll_sample_tick(pll_tk), .adc_red(adc_r), .adc_green(adc_g),
        .adc_blue(adc_b), .tv_line_sync_in(tv_l), .tv_frame_sync_in(tv_f),
        .line_rate_high(lrh), .sample_tick(tick), .pixel(pix), .pixel_valid(p_valid),
        .pixel_source(src), .internal_cpu_run(cpu_run), .overlay_enable(o[0]),
        .overlay_halftone(o[1]), .overlay_red(o[2]), .overlay_green(o[3]),
        .overlay_blue(o[4]));
    rgbm_partner rgbm_partner_inst (.clk(clk), .sel(sel), .word(word), .ovl(ovl),
        .r_lo_out(r_lo_out), .r_lo_oe(r_lo_oe), .b_out(b_out), .b_oe(b_oe), .r_hi(r_hi),
        .r2(r2), .r_lo(r_lo), .g_hi(g_hi), .g_lo(g_lo), .b_in(b_in));
    // Free-running clock.
    always #5 clk = ~clk;
    function automatic logic [31:0] rnd();
        st = st ^ (st << 13);
        st = st ^ (st >> 17);
        st = st ^ (st << 5);
        return st;
    endfunction : rnd
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] v);
        tests_run++;
        if (v !== e) begin
            miscompares++;
            $display("Error %s expected %h seen %h", nm, e, v);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask : cyc
    task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr   <= a;
        wdata  <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : bus_wr
    task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clk);
        addr   <= a;
        reg_rd <= 1'b1;
        rd_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask : bus_rd
    task automatic close_out();
        $display("Checks %0d, mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    // Monitor: read data stands only in the cycle after the strobe, so it is taken there.
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d) chk("reg_rdata", rd_q.pop_front(), rdata);
        if (p_valid === 1'b1 && watch) begin
            if (pix_q.size() == 0) chk("pixel_count", 1, 0);
            else chk("pixel", pix_q.pop_front(), {src, pix});
        end
    end
    // Watchdog sized well above the few hundred cycles the tests need.
    initial begin
        #300us;
        miscompares++;
        close_out();
    end
    // Main sequence.
    initial begin
        cyc(20);
        srst <= 1'b0;
        bus_rd(`RGBM_ADDR_CTRL, `RGBM_CTRL_RST);
        bus_rd(`RGBM_ADDR_DIVN, `RGBM_DIVN_RST);
        bus_rd(8'h10, 0);
        bus_rd(`RGBM_ADDR_STATUS, 32'h2);
        g = rnd() & 32'hff;
        bus_wr(`RGBM_ADDR_GPO, g);
        bus_rd(`RGBM_ADDR_GPO, g);
        cyc(1);
        chk("blue_out", g, b_out);
        chk("blue_oe", 8'hff, b_oe);
        srst <= 1'b1;
        cyc(2);
        srst <= 1'b0;
        bus_rd(`RGBM_ADDR_GPO, `RGBM_GPO_RST);
        $display("Test registers finished");
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            g = rnd();
            {adc_r, adc_g, adc_b} <= g[23:0];
            pll_tk <= 1'b1;
            pix_q.push_back({rgbm_pkg::RGBM_SRC_ADC, g[23:0]});
        end
        @(posedge clk);
        pll_tk <= 1'b0;
        sel <= 1'b1;
        cyc(4);
        chk("pin_oe", 0, {b_oe, r_lo_oe});
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            g = rnd();
            word <= g[23:0];
            pll_tk <= 1'b0;
            cyc(4);
            pll_tk <= 1'b1;
            pix_q.push_back({rgbm_pkg::RGBM_SRC_EXT, g[23:0]});
        end
        @(posedge clk);
        pll_tk <= 1'b0;
        sel <= 1'b0;
        $display("Test pixel paths finished");
        for (int i = 0; i < 4; i++) begin
            @(posedge clk);
            g = rnd();
            ovl <= g[4:0];
            {tv_l, tv_f} <= g[6:5];
            cyc(5);
            chk("overlay", g[4:0], o);
            chk("tv_sync", g[6:5], r_lo_out);
            chk("pin_oe", 10'h3ff, {b_oe, r_lo_oe});
        end
        cpu_en <= 1'b1;
        cyc(4);
        for (int i = 0; i < 4; i++) begin
            g = rnd();
            lrh <= g[0];
            cyc(2);
            chk("gpo0", g[0], b_out[0]);
        end
        chk("cpu_run", 1, cpu_run);
        cpu_en <= 1'b0;
        lrh <= 1'b1;
        cyc(4);
        chk("cpu_run", 0, cpu_run);
        chk("gpo0", 0, b_out[0]);
        $display("Test overlay and cpu finished");
        bus_wr(`RGBM_ADDR_DIVN, 4);
        src_n <= 1'b0;
        watch <= 1'b0;
        n_tk = 0;
        n_div = 0;
        for (int i = 0; i < 160; i++) begin
            @(posedge clk);
            ext_ck <= (i % 8) < 4;
            @(negedge clk);
            if (i >= 32) n_tk += (tick === 1'b1);
            if (i >= 32) n_div += (div_o === 1'b1 && dp === 1'b0);
            dp = div_o;
        end
        chk("ext_ticks", 16, n_tk);
        chk("div_rises", 4, n_div);
        for (int i = 0; i < 8; i++) begin
            bus_wr(`RGBM_ADDR_CTRL, {28'h0, i[2], 1'b1, i[1], i[0]});
            hs <= i[0];
            cyc(4);
            chk("clamp", (i[0] == i[2]) ^ i[1], clamp_o);
            chk("div_pol", 1'b1 ^ i[0], div_o);
        end
        $display("Test clocks finished");
        chk("pixel_left", 0, pix_q.size());
        close_out();
    end
endmodule : testbench
`default_nettype wire
